// file: verilog/flash_seq.sv
// Purpose: Flash programming sequencer reached over AXI4-Lite
// Assumes: One clock, durations counted in core_clk cycles
// Notes: Refused operations leave the array untouched
// Functional notes
// - Identity read returns signature for address
// - Chip erase clears everything, ignores locks
// - Block erase clears selected bank if unlocked
// - Sector erase clears addressed sector if unlocked
// - Program only erased byte in unlocked bank
// - Lock set commands set their lock bit
// - Lock bits cleared only by chip erase
// - Boot bits set, cleared only by chip erase
// - Verify returns byte only when bank unlocked
// - Durations counted in clock cycles
//
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
module flash_seq
    import flash_seq_pkg::*;
#(
    parameter int CHIP_CYC = CHIP_ERASE_CYC,
    parameter int BLOCK_CYC = BLOCK_ERASE_CYC,
    parameter int SECTOR_CYC = SECTOR_ERASE_CYC,
    parameter int PROG_CYC = BYTE_PROG_CYC,
    parameter int LOCK_CYC = LOCK_PROG_CYC
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Write address and data channels
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // Write response channel
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // Read channels
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    seq_state_t state_reg;
    logic [3:0] op_reg;
    logic [TMR_W-1:0] timer_reg;
    logic [MEM_AW-1:0] sweep_reg, sweep_last_reg;
    logic sweep_on_reg, bank_reg, refused_reg;
    logic [2:0] lock_reg;
    logic [1:0] boot_reg;
    logic [7:0] result_reg, wdata_reg;
    logic [15:0] addr_reg;
    logic aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg, rdata_reg;
    logic [3:0] w_strb_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [8:0] rd_data;

    // Cell index of a bank-relative address
    function automatic logic [MEM_AW-1:0] mem_index(input logic bank,
        input logic [15:0] a);
        mem_index = bank ? (17'(BANK0_BYTES) + {4'h0, a[12:0]})
                         : {1'b0, a};
    endfunction

    // Mapped register offsets, used by both read and write paths
    function automatic logic reg_known(input logic [7:0] a);
        reg_known = (a == CMD_OFS) || (a == ADDR_OFS) || (a == WDATA_OFS)
            || (a == STATUS_OFS) || (a == RESULT_OFS);
    endfunction

    // Command codes the sequencer accepts
    function automatic logic op_known(input logic [3:0] c);
        op_known = (c >= IDENTITY_READ_CMD) && (c <= BYTE_VERIFY_CMD)
            || (c >= LOCK_BIT_SET_CMD) && (c <= BOOT_CONFIG_SET_CMD + 4'h1);
    endfunction

    // Bus handshakes and write decode
    wire busy = (state_reg != S_IDLE);
    wire wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
    wire wr_cmd = wr_fire && (aw_addr_reg == CMD_OFS) && w_strb_reg[0];
    wire cmd_ok = !busy && op_known(w_data_reg[3:0]);
    wire cmd_go = wr_cmd && cmd_ok;
    wire wr_addr_hit = wr_fire && (aw_addr_reg == ADDR_OFS) && !busy;
    wire wr_wdata_hit = wr_fire && (aw_addr_reg == WDATA_OFS) && !busy;
    wire wr_bad = !reg_known(aw_addr_reg) || (wr_cmd && !cmd_ok);
    wire rd_fire = arvalid && !rvalid_reg;
    assign awready = !aw_full_reg;
    assign wready = !w_full_reg;
    assign arready = !rvalid_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;

    // Status word and read selection
    wire [31:0] status_word = {24'h0, boot_reg, lock_reg, bank_reg,
        refused_reg, busy};
    wire [31:0] rd_mux =
        (araddr == CMD_OFS) ? {28'h0, op_reg} :
        (araddr == ADDR_OFS) ? {16'h0, addr_reg} :
        (araddr == WDATA_OFS) ? {24'h0, wdata_reg} :
        (araddr == STATUS_OFS) ? status_word :
        (araddr == RESULT_OFS) ? {24'h0, result_reg} : 32'h0;

    // Operation decode during evaluation
    wire in_eval = (state_reg == S_EVAL);
    wire bank_locked = bank_reg ? (lock_reg[1] | lock_reg[2])
                                : (lock_reg[0] | lock_reg[2]);
    wire needs_unlock = (op_reg == BLOCK_ERASE_CMD)
        || (op_reg == SECTOR_ERASE_CMD) || (op_reg == BYTE_PROG_CMD)
        || (op_reg == BYTE_VERIFY_CMD);
    wire is_erase = (op_reg == CHIP_ERASE_CMD)
        || (op_reg == BLOCK_ERASE_CMD) || (op_reg == SECTOR_ERASE_CMD);
    wire is_lock = (op_reg >= LOCK_BIT_SET_CMD)
        && (op_reg <= LOCK_BIT_SET_CMD + 4'h2);
    wire is_boot = (op_reg >= BOOT_CONFIG_SET_CMD);
    wire [1:0] lock_sel = 2'(op_reg - LOCK_BIT_SET_CMD);
    wire boot_sel = op_reg[0] ^ BOOT_CONFIG_SET_CMD[0];
    wire refuse = in_eval && ((needs_unlock && bank_locked)
        || ((op_reg == BYTE_PROG_CMD) && rd_data[8]));

    // Sweep bounds per erase kind
    wire [MEM_AW-1:0] sec_base = mem_index(bank_reg,
        {addr_reg[15:7], 7'h00});
    wire [MEM_AW-1:0] sw_first =
        (op_reg == CHIP_ERASE_CMD) ? '0 :
        (op_reg == BLOCK_ERASE_CMD) ? mem_index(bank_reg, 16'h0000) :
        sec_base;
    wire [MEM_AW-1:0] sw_last =
        (op_reg == CHIP_ERASE_CMD) ? MEM_AW'(MEM_DEPTH - 1) :
        (op_reg == BLOCK_ERASE_CMD) ?
            (bank_reg ? MEM_AW'(MEM_DEPTH - 1)
                      : MEM_AW'(BANK0_BYTES - 1)) :
        sec_base + MEM_AW'(SECTOR_BYTES - 1);

    // Duration in cycles, so timing scales with the clock
    wire [TMR_W-1:0] dur =
        (op_reg == IDENTITY_READ_CMD) ? TMR_W'(ID_HOLD_CYC) :
        (op_reg == BANK_SELECT_CMD) ? TMR_W'(BANK_SEL_CYC) :
        (op_reg == CHIP_ERASE_CMD) ? TMR_W'(CHIP_CYC) :
        (op_reg == BLOCK_ERASE_CMD) ? TMR_W'(BLOCK_CYC) :
        (op_reg == SECTOR_ERASE_CMD) ? TMR_W'(SECTOR_CYC) :
        (op_reg == BYTE_PROG_CMD) ? TMR_W'(PROG_CYC) :
        (op_reg == BYTE_VERIFY_CMD) ? TMR_W'(VERIFY_CYC) :
        TMR_W'(LOCK_CYC);

    // Identity byte for the presented address
    wire [7:0] id_byte = (addr_reg[1:0] == 2'h0) ? ID_MAKER :
        (addr_reg[1:0] == 2'h1) ? ID_PART : ERASED_BYTE;

    // Run completes only when both the timer and the sweep are done
    wire run_done = (state_reg == S_RUN) && (timer_reg <= TMR_W'(1))
        && !sweep_on_reg;
    wire chip_clear = run_done && (op_reg == CHIP_ERASE_CMD);

    // Array port: program in evaluation, erase during the sweep
    wire mem_we = (in_eval && (op_reg == BYTE_PROG_CMD) && !refuse)
        || ((state_reg == S_RUN) && sweep_on_reg);
    wire [MEM_AW-1:0] mem_waddr = (state_reg == S_RUN) ? sweep_reg
        : mem_index(bank_reg, addr_reg);
    wire [8:0] mem_wdata = (state_reg == S_RUN) ? {1'b0, ERASED_BYTE}
        : {1'b1, wdata_reg};
    wire [MEM_AW-1:0] mem_raddr = mem_index(bank_reg, addr_reg);

    flash_array u_array (
        .core_clk(core_clk),
        .rd_addr(mem_raddr),
        .rd_data_reg(rd_data),
        .wr_en(mem_we),
        .wr_addr(mem_waddr),
        .wr_data(mem_wdata)
    );

    // AXI4-Lite write side; address and data may arrive in either order
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= awaddr;
            end
            if (wvalid && wready)
            begin
                w_full_reg <= 1'b1;
                w_data_reg <= wdata;
                w_strb_reg <= wstrb;
            end
            if (wr_fire)
            begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_bad ? RESP_SLVERR : RESP_OKAY;
            end
            else if (bready)
                bvalid_reg <= 1'b0;
        end
    end

    // AXI4-Lite read side, one cycle from address to data
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= RESP_OKAY;
        end
        else if (rd_fire)
        begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_mux;
            rresp_reg <= reg_known(araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rready)
            rvalid_reg <= 1'b0;
    end

    // Software operand registers; frozen while an operation runs
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addr_reg <= ADDR_RST;
            wdata_reg <= WDATA_RST;
        end
        else
        begin
            if (wr_addr_hit && w_strb_reg[0])
                addr_reg[7:0] <= w_data_reg[7:0];
            if (wr_addr_hit && w_strb_reg[1])
                addr_reg[15:8] <= w_data_reg[15:8];
            if (wr_wdata_hit && w_strb_reg[0])
                wdata_reg <= w_data_reg[7:0];
        end
    end

    // Sequencer: fetch the cell, judge locks, then time the operation
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= S_IDLE;
            op_reg <= 4'h0;
            timer_reg <= '0;
            refused_reg <= 1'b0;
        end
        else
        begin
            case (state_reg)
                S_IDLE:
                    if (cmd_go)
                    begin
                        op_reg <= w_data_reg[3:0];
                        refused_reg <= 1'b0;
                        state_reg <= S_FETCH;
                    end
                S_FETCH:
                    state_reg <= S_EVAL;
                S_EVAL:
                begin
                    // Refusal ends at once and leaves the array untouched
                    refused_reg <= refuse;
                    timer_reg <= dur;
                    state_reg <= refuse ? S_IDLE : S_RUN;
                end
                S_RUN:
                begin
                    if (timer_reg > TMR_W'(1))
                        timer_reg <= timer_reg - TMR_W'(1);
                    if (run_done)
                        state_reg <= S_IDLE;
                end
                default:
                    state_reg <= S_IDLE;
            endcase
        end
    end

    // Erase sweep, one cell a cycle, alongside the erase time; the run waits for whichever ends last
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sweep_on_reg <= 1'b0;
            sweep_reg <= '0;
            sweep_last_reg <= '0;
        end
        else if (in_eval && is_erase && !refuse)
        begin
            sweep_on_reg <= 1'b1;
            sweep_reg <= sw_first;
            sweep_last_reg <= sw_last;
        end
        else if (sweep_on_reg)
        begin
            sweep_reg <= sweep_reg + MEM_AW'(1);
            sweep_on_reg <= (sweep_reg != sweep_last_reg);
        end
    end

    // Bank, lock, boot and result state
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bank_reg <= 1'b0;
            lock_reg <= 3'h0;
            boot_reg <= 2'h0;
            result_reg <= RESULT_RST;
        end
        else if (chip_clear)
        begin
            lock_reg <= 3'h0;
            boot_reg <= 2'h0;
        end
        else if (in_eval)
        begin
            if (op_reg == BANK_SELECT_CMD)
                bank_reg <= wdata_reg[0];
            if (is_lock)
                lock_reg[lock_sel] <= 1'b1;
            if (is_boot)
                boot_reg[boot_sel] <= 1'b1;
            if (op_reg == IDENTITY_READ_CMD)
                result_reg <= id_byte;
            if (op_reg == BYTE_VERIFY_CMD)
                result_reg <= refuse ? ERASED_BYTE : rd_data[7:0];
        end
    end

    // Checks on the sequencer's own behaviour
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_lock_eval;
        in_eval && is_lock;
    endsequence

    property p_lock_set;
        s_lock_eval |=> lock_reg[$past(lock_sel)]
            ##1 lock_reg[$past(lock_sel, 2)];
    endproperty
    a_lock_set: assert property (p_lock_set)
        else $error("lock bit not set by lock command");

    property p_lock_sticky;
        !chip_clear |=> ((lock_reg & $past(lock_reg)) == $past(lock_reg));
    endproperty
    a_lock_sticky: assert property (p_lock_sticky)
        else $error("lock bit cleared without chip erase");

    property p_boot_sticky;
        !chip_clear |=> ((boot_reg & $past(boot_reg)) == $past(boot_reg));
    endproperty
    a_boot_sticky: assert property (p_boot_sticky)
        else $error("boot bit cleared without chip erase");

    property p_chip_clear;
        chip_clear |=> (lock_reg == 3'h0) && (boot_reg == 2'h0) && !busy;
    endproperty
    a_chip_clear: assert property (p_chip_clear)
        else $error("chip erase left protection bits set");

    property p_refuse_quiet;
        refuse |-> !mem_we ##1 (!busy && refused_reg && !sweep_on_reg);
    endproperty
    a_refuse_quiet: assert property (p_refuse_quiet)
        else $error("refused operation touched the array");

    property p_prog_erased;
        mem_we && in_eval |-> !rd_data[8] && !bank_locked;
    endproperty
    a_prog_erased: assert property (p_prog_erased)
        else $error("program on used or locked cell");

    property p_erase_range;
        mem_we && (state_reg == S_RUN) && (op_reg != CHIP_ERASE_CMD)
            |-> (mem_waddr >= mem_index(bank_reg, 16'h0000))
            && (mem_waddr <= (bank_reg ? MEM_AW'(MEM_DEPTH - 1)
                                       : MEM_AW'(BANK0_BYTES - 1)));
    endproperty
    a_erase_range: assert property (p_erase_range)
        else $error("erase left the selected bank");

    property p_verify_data;
        in_eval && (op_reg == BYTE_VERIFY_CMD) && !bank_locked
            |=> result_reg == $past(rd_data[7:0]);
    endproperty
    a_verify_data: assert property (p_verify_data)
        else $error("verify result differs from cell");

    property p_id_data;
        in_eval && (op_reg == IDENTITY_READ_CMD)
            |=> result_reg == $past(id_byte) ##1 busy;
    endproperty
    a_id_data: assert property (p_id_data)
        else $error("identity result wrong");

    property p_go_timed;
        cmd_go |=> (state_reg == S_FETCH) ##1 in_eval ##1 (timer_reg != '0);
    endproperty
    a_go_timed: assert property (p_go_timed)
        else $error("operation did not start its timer");
endmodule // flash_seq

// file: verilog/flash_seq_pkg.sv
// Purpose: Shared constants for the flash programming sequencer
// Assumes: 200 MHz core clock, AXI4-Lite register access
// Notes: Durations are kept in their own units; cycle counts derive here
package flash_seq_pkg;
    // Clock rate used to turn times into cycle counts
    localparam int CLK_MHZ = 200;
    localparam int ID_HOLD_US = 1;
    localparam int BANK_SEL_NS = 500;
    localparam int CHIP_ERASE_MS = 150;
    localparam int BLOCK_ERASE_MS = 100;
    localparam int SECTOR_ERASE_MS = 30;
    localparam int BYTE_PROG_US = 50;
    localparam int LOCK_PROG_US = 80;
    // Least time rounds up, longest time rounds down (all exact here)
    localparam int ID_HOLD_CYC = ID_HOLD_US * CLK_MHZ;
    localparam int BANK_SEL_CYC = BANK_SEL_NS * CLK_MHZ / 1000;
    localparam int CHIP_ERASE_CYC = CHIP_ERASE_MS * 1000 * CLK_MHZ;
    localparam int BLOCK_ERASE_CYC = BLOCK_ERASE_MS * 1000 * CLK_MHZ;
    localparam int SECTOR_ERASE_CYC = SECTOR_ERASE_MS * 1000 * CLK_MHZ;
    localparam int BYTE_PROG_CYC = BYTE_PROG_US * CLK_MHZ;
    localparam int LOCK_PROG_CYC = LOCK_PROG_US * CLK_MHZ;
    localparam int VERIFY_CYC = 1;
    localparam int TMR_W = 25;

    // Flash array geometry
    localparam int MEM_AW = 17;
    localparam int BANK0_BYTES = 65536;
    localparam int BANK1_BYTES = 8192;
    localparam int SECTOR_BYTES = 128;
    localparam int MEM_DEPTH = BANK0_BYTES + BANK1_BYTES;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // Register byte offsets
    localparam logic [7:0] CMD_OFS = 8'h00;
    localparam logic [7:0] ADDR_OFS = 8'h04;
    localparam logic [7:0] WDATA_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0C;
    localparam logic [7:0] RESULT_OFS = 8'h10;

    // Status field positions
    localparam int ST_BUSY = 0;
    localparam int ST_REFUSED = 1;
    localparam int ST_BANK = 2;
    localparam int ST_LOCK = 3;
    localparam int ST_BOOT = 6;

    // Reset values
    localparam logic [15:0] ADDR_RST = 16'h0000;
    localparam logic [7:0] WDATA_RST = 8'hFF;
    localparam logic [7:0] RESULT_RST = 8'h00;

    // Identity bytes: values are arbitrary
    localparam logic [7:0] ID_MAKER = 8'hA5;
    localparam logic [7:0] ID_PART = 8'h3C;

    // Command codes written to the command register
    localparam logic [3:0] IDENTITY_READ_CMD = 4'h1;
    localparam logic [3:0] BANK_SELECT_CMD = 4'h2;
    localparam logic [3:0] CHIP_ERASE_CMD = 4'h3;
    localparam logic [3:0] BLOCK_ERASE_CMD = 4'h4;
    localparam logic [3:0] SECTOR_ERASE_CMD = 4'h5;
    localparam logic [3:0] BYTE_PROG_CMD = 4'h6;
    localparam logic [3:0] BYTE_VERIFY_CMD = 4'h7;
    localparam logic [3:0] LOCK_BIT_SET_CMD = 4'h8;
    localparam logic [3:0] BOOT_CONFIG_SET_CMD = 4'hB;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {S_IDLE, S_FETCH, S_EVAL, S_RUN} seq_state_t;
endpackage

// file: verilog/flash_array.sv
// Purpose: Flash cell array, one data byte plus a programmed flag per cell
// Assumes: Single clock, one read and one write port
// Notes: Read data always come from a register, one cycle after address
`timescale 1ns/100ps
module flash_array
    import flash_seq_pkg::*;
(
    // Clock
    input wire logic core_clk,
    // Read port
    input wire logic [MEM_AW-1:0] rd_addr,
    output logic [8:0] rd_data_reg,
    // Write port
    input wire logic wr_en,
    input wire logic [MEM_AW-1:0] wr_addr,
    input wire logic [8:0] wr_data
);
    logic [8:0] cells [0:MEM_DEPTH-1];

    // No reset on the array: contents survive like real cells
    always_ff @(posedge core_clk)
    begin
        if (wr_en)
            cells[wr_addr] <= wr_data;
        rd_data_reg <= cells[rd_addr];
    end
endmodule // flash_array

// file: tb/host_model.sv
// Purpose: AXI4-Lite programmer host model
// Assumes: One write and one read under way at a time
// Notes: A wait that runs out returns response 3
`timescale 1ns/100ps
module host_model
(
    // Clock
    input wire logic core_clk,
    // Write channels
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    // Read channels
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    // Idle bus at time zero
    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
    end

    // Each channel released only at its own handshake edge
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
        output logic [1:0] r);
        int n;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= v;
        {awvalid, wvalid, bready} <= 3'b111;
        r = 2'h3;
        for (n = 0; n < 500; n++)
        begin
            @(posedge core_clk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid)
            begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask

    // Read data taken at the edge that shows rvalid
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        int n;
        @(posedge core_clk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        {d, r} = '1;
        for (n = 0; n < 500; n++)
        begin
            @(posedge core_clk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid)
            begin
                {d, r} = {rdata, rresp};
                rready <= 1'b0;
                break;
            end
        end
    endtask
endmodule // host_model

// file: tb/testbench.sv
// Purpose: Self-checking bench for the flash sequencer
// Assumes: Short duration parameters, erase sweeps dominate
// Notes: One chip erase only, to keep the run short
`timescale 1ns/100ps
module testbench
    import flash_seq_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    int err_count = 0;
    int num_checks = 0;

    // 200 MHz clock
    always #2.5 core_clk = ~core_clk;

    // Short counts; cycle counting keeps durations exact
    flash_seq #(.CHIP_CYC(20), .BLOCK_CYC(20), .SECTOR_CYC(20),
        .PROG_CYC(20), .LOCK_CYC(20)) DUT (
        .core_clk(core_clk), .rst_n(rst_n), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready));

    host_model u_host (
        .core_clk(core_clk), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready));

    task test_done();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task wreg(input logic [7:0] a, input logic [31:0] v,
        input logic [1:0] er);
        u_host.wr(a, v, r);
        chk({30'h0, r}, {30'h0, er});
    endtask

    task rreg(input logic [7:0] a, input logic [31:0] ev);
        u_host.rd(a, d, r);
        chk(d, ev);
    endtask

    // Poll busy; no fixed time assumed for the operation
    task wait_idle();
        int n;
        for (n = 0; n < 40000; n++)
        begin
            u_host.rd(STATUS_OFS, d, r);
            if (d[ST_BUSY] === 1'b0)
                break;
        end
        if (n == 40000)
        begin
            err_count++;
            $display("MISMATCH t=%0t busy never cleared", $time);
            test_done();
        end
    endtask

    // Load address and data, run one command, check status
    task run(input logic [15:0] a, input logic [7:0] w,
        input logic [3:0] c, input logic [7:0] st);
        wreg(ADDR_OFS, {16'h0, a}, RESP_OKAY);
        wreg(WDATA_OFS, {24'h0, w}, RESP_OKAY);
        wreg(CMD_OFS, {28'h0, c}, RESP_OKAY);
        wait_idle();
        rreg(STATUS_OFS, {24'h0, st});
    endtask

    // Hang guard
    initial
    begin
        repeat (99000) @(posedge core_clk);
        err_count++;
        $display("MISMATCH t=%0t run limit reached", $time);
        test_done();
    end

    initial
    begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        rreg(ADDR_OFS, 32'h0);
        rreg(WDATA_OFS, 32'hFF);
        rreg(RESULT_OFS, 32'h0);
        rreg(STATUS_OFS, 32'h0);
        rreg(CMD_OFS, 32'h0);
        rreg(8'h14, 32'h0);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        $display("test reset values done");
        // Protection bits set first so the chip erase must clear them
        run(16'h0, 8'hFF, LOCK_BIT_SET_CMD + 4'h2, 8'h20);
        run(16'h0, 8'hFF, BOOT_CONFIG_SET_CMD, 8'h60);
        run(16'h0, 8'hFF, CHIP_ERASE_CMD, 8'h00);
        run(16'h0, 8'hFF, IDENTITY_READ_CMD, 8'h00);
        rreg(RESULT_OFS, {24'h0, ID_MAKER});
        run(16'h1, 8'hFF, IDENTITY_READ_CMD, 8'h00);
        rreg(RESULT_OFS, {24'h0, ID_PART});
        run(16'h0100, 8'h5A, BYTE_PROG_CMD, 8'h00);
        run(16'h0200, 8'h33, BYTE_PROG_CMD, 8'h00);
        run(16'h0100, 8'h00, BYTE_PROG_CMD, 8'h02);
        run(16'h0100, 8'hFF, BYTE_VERIFY_CMD, 8'h00);
        rreg(RESULT_OFS, 32'h5A);
        run(16'h0100, 8'hFF, SECTOR_ERASE_CMD, 8'h00);
        run(16'h0100, 8'hFF, BYTE_VERIFY_CMD, 8'h00);
        rreg(RESULT_OFS, 32'hFF);
        run(16'h0200, 8'hFF, BYTE_VERIFY_CMD, 8'h00);
        rreg(RESULT_OFS, 32'h33);
        $display("test program and sector done");
        run(16'h0, 8'h01, BANK_SELECT_CMD, 8'h04);
        run(16'h0010, 8'h77, BYTE_PROG_CMD, 8'h04);
        run(16'h0010, 8'hFF, BLOCK_ERASE_CMD, 8'h04);
        run(16'h0010, 8'hFF, BYTE_VERIFY_CMD, 8'h04);
        rreg(RESULT_OFS, 32'hFF);
        run(16'h0, 8'h00, BANK_SELECT_CMD, 8'h00);
        run(16'h0200, 8'hFF, BYTE_VERIFY_CMD, 8'h00);
        rreg(RESULT_OFS, 32'h33);
        $display("test block erase done");
        run(16'h0, 8'hFF, LOCK_BIT_SET_CMD, 8'h08);
        run(16'h0200, 8'hFF, BYTE_VERIFY_CMD, 8'h0A);
        rreg(RESULT_OFS, 32'hFF);
        run(16'h0200, 8'hFF, SECTOR_ERASE_CMD, 8'h0A);
        run(16'h0200, 8'hFF, BLOCK_ERASE_CMD, 8'h0A);
        run(16'h0300, 8'h11, BYTE_PROG_CMD, 8'h0A);
        run(16'h0, 8'h01, BANK_SELECT_CMD, 8'h0C);
        run(16'h0020, 8'h66, BYTE_PROG_CMD, 8'h0C);
        run(16'h0020, 8'hFF, BYTE_VERIFY_CMD, 8'h0C);
        rreg(RESULT_OFS, 32'h66);
        run(16'h0, 8'hFF, LOCK_BIT_SET_CMD + 4'h1, 8'h1C);
        run(16'h0, 8'hFF, LOCK_BIT_SET_CMD + 4'h2, 8'h3C);
        run(16'h0, 8'hFF, BOOT_CONFIG_SET_CMD, 8'h7C);
        run(16'h0, 8'hFF, BOOT_CONFIG_SET_CMD + 4'h1, 8'hFC);
        run(16'h0020, 8'hFF, BLOCK_ERASE_CMD, 8'hFE);
        $display("test locks done");
        wreg(CMD_OFS, {28'h0, LOCK_BIT_SET_CMD}, RESP_OKAY);
        wreg(CMD_OFS, {28'h0, IDENTITY_READ_CMD}, RESP_SLVERR);
        wait_idle();
        wreg(CMD_OFS, 32'hF, RESP_SLVERR);
        $display("test refused writes done");
        test_done();
    end
endmodule // testbench
